// File: inc/dma_src_consts.svh
// constants for the dma activation source selector
// assumes a single 125 MHz system clock and synchronous active-low reset
`ifndef DMA_SRC_CONSTS_SVH
`define DMA_SRC_CONSTS_SVH

`define FACTOR_MSB        3
`define FACTOR_LSB        0
`define FACTOR_WIDTH      4
`define FACTOR_RESET      4'h0
`define HALF_COUNT        4
`define CHANNEL_COUNT     2
`define SERIAL_PORTS      2
`define TIMER_CHANNELS    6
`define PIN_IDLE_LEVEL    1'h1

`endif

// File: inc/dma_src_pkg.sv
// types for the dma activation source selector
// assumes dma_src_consts.svh is on the include path
`include "dma_src_consts.svh"

package dma_src_pkg;

    typedef enum logic [3:0] {
        factor_none_type_0 = 4'h0,
        factor_adc_end     = 4'h1,
        factor_pin_fall    = 4'h2,
        factor_pin_low     = 4'h3,
        factor_ser0_tx     = 4'h4,
        factor_ser0_rx     = 4'h5,
        factor_ser1_tx     = 4'h6,
        factor_ser1_rx     = 4'h7,
        factor_timer0      = 4'h8,
        factor_timer1      = 4'h9,
        factor_timer2      = 4'hA,
        factor_timer3      = 4'hB,
        factor_timer4      = 4'hC,
        factor_timer5      = 4'hD,
        factor_bad_e       = 4'hE,
        factor_bad_f       = 4'hF
    } factor_type;

endpackage

// File: src/dma_activation_source_select.sv
// activation source selection for the four channel halves 0A, 0B, 1A, 1B
// assumes peripheral events are one-cycle pulses on sys_clk and the
// request pins are asynchronous; halves are indexed 0A=0, 0B=1, 1A=2, 1B=3
`include "dma_src_consts.svh"

// How it works
// - each half keeps a four-bit factor field in bits 3..0, writable and readable, reset to zero.
// - code 0001 starts a transfer on the converter conversion-end event.
// - codes 0100/0101 follow serial port 0 transmit/receive end, 0110/0111 serial port 1.
// - codes 1000 to 1101 follow capture A of timer channels 0 to 5.
// - on half B code 0010 starts on a pin falling edge, the first one after enable on low level.
// - on half B code 0011 keeps requesting while the pin stays low.
// - when several halves wait on one source the highest-priority half is started first.
// - every half decodes its own factor field, but all four share one fixed-priority start per cycle.
module dma_activation_source_select
    import dma_src_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // factor field access, four bits per half
    input  wire logic [3:0]  factor_wr,
    input  wire logic [15:0] factor_wdata,
    output logic      [15:0] factor_rd,
    // transfer enable per half
    input  wire logic [3:0]  transfer_enable,
    // on-chip activation events
    input  wire logic        adc_conv_end,
    input  wire logic [1:0]  serial_tx_end,
    input  wire logic [1:0]  serial_rx_end,
    input  wire logic [5:0]  timer_capture_a,
    // external request pins, one per channel, for half B
    input  wire logic [1:0]  external_transfer_request_n,
    // transfer start per half, one start for each cycle it is high
    output logic      [3:0]  transfer_start
);

    factor_type  factor [`HALF_COUNT];
    logic [3:0]  pending;
    logic [3:0]  first_pending;
    logic [3:0]  hit;
    logic [3:0]  grant;
    logic [3:0]  next_transfer_start;
    logic [1:0]  pin_low;
    logic [1:0]  pin_fall;

    // decodes the selected source; prohibited codes fall to zero
    function automatic logic source_hit(input factor_type f,
                                        input logic       is_b,
                                        input logic       first,
                                        input logic       low,
                                        input logic       fall,
                                        input logic       adc,
                                        input logic [1:0] tx,
                                        input logic [1:0] rx,
                                        input logic [5:0] tim);
        logic r;
        r = 1'h0;
        case (f)
            factor_adc_end:  r = adc;
            factor_pin_fall: r = is_b & (fall | (first & low));
            factor_pin_low:  r = is_b & low;
            factor_ser0_tx:  r = tx[0];
            factor_ser0_rx:  r = rx[0];
            factor_ser1_tx:  r = tx[1];
            factor_ser1_rx:  r = rx[1];
            factor_timer0:   r = tim[0];
            factor_timer1:   r = tim[1];
            factor_timer2:   r = tim[2];
            factor_timer3:   r = tim[3];
            factor_timer4:   r = tim[4];
            factor_timer5:   r = tim[5];
            default:         r = 1'h0;
        endcase
        return r;
    endfunction

    genvar c;
    generate
        for (c = 0; c < `CHANNEL_COUNT; c++)
        begin : g_pin
            dma_request_sync u_sync
            (
                .sys_clk                     (sys_clk),
                .rstn                        (rstn),
                .external_transfer_request_n (external_transfer_request_n[c]),
                .pin_low                     (pin_low[c]),
                .pin_fall                    (pin_fall[c])
            );
        end
    endgenerate

    genvar h;
    generate
        for (h = 0; h < `HALF_COUNT; h++)
        begin : g_half
            factor_type next_factor;
            logic       next_pending;
            logic       next_first;

            // each half decodes its own field against the shared events
            always_comb
            begin
                next_factor = factor_wr[h]
                            ? factor_type'(factor_wdata[4*h+`FACTOR_MSB -: `FACTOR_WIDTH])
                            : factor[h];
                // a low level starts only the first transfer; later ones need a fresh edge
                hit[h]      = source_hit(factor[h], (h % 2) == 1,
                                         first_pending[h] & ~grant[h],
                                         pin_low[h/2], pin_fall[h/2], adc_conv_end,
                                         serial_tx_end, serial_rx_end, timer_capture_a);
                // a new hit in the grant cycle keeps the request alive
                next_pending = transfer_enable[h] & (hit[h] | (pending[h] & ~grant[h]));
                // the first transfer after enable may start on a plain low level
                next_first   = ~transfer_enable[h] | (first_pending[h] & ~grant[h]);
            end

            always_ff @(posedge sys_clk)
            begin
                if (!rstn)
                begin
                    factor[h]        <= factor_type'(`FACTOR_RESET);
                    pending[h]       <= 1'h0;
                    first_pending[h] <= 1'h1;
                end
                else
                begin
                    factor[h]        <= next_factor;
                    pending[h]       <= next_pending;
                    first_pending[h] <= next_first;
                end
            end

            assign factor_rd[4*h+`FACTOR_MSB -: `FACTOR_WIDTH] = factor[h];
        end
    endgenerate

    // fixed priority, 0A highest, 1B lowest; one start per cycle
    always_comb
    begin
        grant = 4'h0;
        if (pending[0])
        begin
            grant = 4'h1;
        end
        else if (pending[1])
        begin
            grant = 4'h2;
        end
        else if (pending[2])
        begin
            grant = 4'h4;
        end
        else if (pending[3])
        begin
            grant = 4'h8;
        end
        next_transfer_start = grant;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            transfer_start <= 4'h0;
        end
        else
        begin
            transfer_start <= next_transfer_start;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    a_factor_reset_zero: assert property ($rose(rstn) |-> factor_rd == 16'h0)
        else $error("factor field not zero after reset");
    a_factor_write_read: assert property (
        factor_wr[1] |=> factor_rd[7:4] == $past(factor_wdata[7:4]))
        else $error("half 0B field did not take the written value");
    a_adc_start_half: assert property (
        transfer_enable[2] && factor[2] == factor_adc_end && adc_conv_end |=> pending[2])
        else $error("converter event did not raise request on half 1A");
    a_serial_rx_start: assert property (
        transfer_enable[0] && factor[0] == factor_ser1_rx && serial_rx_end[1] |=> pending[0])
        else $error("serial receive event did not raise request on half 0A");
    a_timer_capture_start: assert property (
        transfer_enable[3] && factor[3] == factor_timer5 && timer_capture_a[5] |=> pending[3])
        else $error("timer 5 capture did not raise request on half 1B");
    a_pin_fall_start: assert property (
        transfer_enable[1] && factor[1] == factor_pin_fall && pin_fall[0]
        ##1 transfer_enable[1] && !pending[0] |-> ##[1:4] transfer_start[1])
        else $error("pin falling edge did not start half 0B");
    a_first_low_once: assert property (
        grant[1] && factor[1] == factor_pin_fall && first_pending[1] && !pin_fall[0]
        |=> !pending[1])
        else $error("low level started half 0B more than once");
    a_pin_low_hold: assert property (
        transfer_enable[3] && factor[3] == factor_pin_low && pin_low[1] |=> pending[3])
        else $error("low pin did not keep request on half 1B");
    a_priority_order: assert property (
        pending[0] && pending[1] |=> transfer_start[0] && !transfer_start[1])
        else $error("lower priority half started first");
    a_start_onehot: assert property ($onehot0(transfer_start))
        else $error("more than one half started at once");
    a_disable_drops: assert property (!transfer_enable[1] |=> !pending[1])
        else $error("disabled half 0B kept a request");
    a_prohibited_idle: assert property (
        factor[0] inside {factor_none_type_0, factor_bad_e, factor_bad_f} && !pending[0]
        |=> !pending[0])
        else $error("prohibited code raised a request on half 0A");
    a_pin_ignored_a: assert property (
        factor[2] inside {factor_pin_fall, factor_pin_low} && !pending[2] |=> !pending[2])
        else $error("pin code raised a request on half 1A");

    c_two_halves_wait: cover property (pending[0] && pending[2]);
    c_pin_first_low: cover property (first_pending[1] && pin_low[0] && grant[1]);
    c_timer_start: cover property (factor[2] == factor_timer3 && transfer_start[2]);
    c_level_repeat: cover property (transfer_start[3] ##2 transfer_start[3]);

endmodule

// File: src/dma_request_sync.sv
// synchroniser and filter for one active-low external transfer request pin
// assumes the pin is asynchronous to sys_clk and idles high
`include "dma_src_consts.svh"

module dma_request_sync
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // pin
    input  wire logic external_transfer_request_n,
    // filtered request
    output logic      pin_low,
    output logic      pin_fall
);

    logic sync1;
    logic sync2;
    logic sync3;
    logic next_pin_low;
    logic next_pin_fall;
    logic agree;

    // a level counts only once the second and third stages agree
    always_comb
    begin
        agree         = (sync2 == sync3);
        next_pin_low  = agree ? ~sync3 : pin_low;
        next_pin_fall = agree & ~sync3 & ~pin_low;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sync1    <= `PIN_IDLE_LEVEL;
            sync2    <= `PIN_IDLE_LEVEL;
            sync3    <= `PIN_IDLE_LEVEL;
            pin_low  <= 1'h0;
            pin_fall <= 1'h0;
        end
        else
        begin
            sync1    <= external_transfer_request_n;
            sync2    <= sync1;
            sync3    <= sync2;
            pin_low  <= next_pin_low;
            pin_fall <= next_pin_fall;
        end
    end

endmodule

// File: testbench/dma_activation_source_select_bench.sv
// self-checking bench for the activation source selector
// assumes the selector and event_source_model are compiled before it
module dma_activation_source_select_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, rstn, go, level_mode, adc_conv_end;
    logic [3:0]  factor_wr, transfer_enable, sel, transfer_start;
    logic [15:0] factor_wdata, factor_rd, shadow, lfsr;
    logic [1:0]  pin_low_req, serial_tx_end, serial_rx_end, external_transfer_request_n;
    logic [5:0]  timer_capture_a;
    logic [15:0] bad [2] = '{16'hE203, 16'h0FFE};
    int          fails = 0, samples_checked = 0, cyc = 0, level_b = 0, level_a = 0;
    int          level_d = 0;
    int          note_mask [$], note_cyc [$];

    dma_activation_source_select u_dma_activation_source_select (.sys_clk(sys_clk),
        .rstn(rstn), .factor_wr(factor_wr), .factor_wdata(factor_wdata),
        .factor_rd(factor_rd), .transfer_enable(transfer_enable),
        .adc_conv_end(adc_conv_end), .serial_tx_end(serial_tx_end),
        .serial_rx_end(serial_rx_end), .timer_capture_a(timer_capture_a),
        .external_transfer_request_n(external_transfer_request_n),
        .transfer_start(transfer_start));
    event_source_model u_event_source_model (.sys_clk(sys_clk), .go(go), .sel(sel),
        .pin_low_req(pin_low_req), .adc_conv_end(adc_conv_end), .serial_tx_end(serial_tx_end),
        .serial_rx_end(serial_rx_end), .timer_capture_a(timer_capture_a),
        .external_transfer_request_n(external_transfer_request_n));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic results;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_start(input int m, input int c);
        chk("start half", 16'(m), {12'h000, transfer_start});
        chk("start in time", 16'h0001, 16'(cyc - c <= 12));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr_all(input logic [15:0] v);
        factor_wdata = v;
        factor_wr = 4'hF;
        tick(1);
        factor_wr = 4'h0;
        shadow = v;
    endtask
    task automatic note(input logic [3:0] m);
        for (int h = 0; h < 4; h++)
            if (m[h])
            begin
                note_mask.push_back(1 << h);
                note_cyc.push_back(cyc);
            end
    endtask
    task automatic fire(input logic [3:0] code, input logic [3:0] m);
        note(m);
        sel = code;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(12);
    endtask

    // outside level mode every start is matched with the oldest note; a start with none is an error
    always @(negedge sys_clk)
        if (rstn && transfer_start !== 4'h0)
        begin
            if (level_mode)
            begin
                level_b += transfer_start[1];
                level_d += transfer_start[3];
                level_a += transfer_start[0] | transfer_start[2];
            end
            else if (note_mask.size() == 0)
                chk("unexpected start", 16'h0000, {12'h000, transfer_start});
            else
                chk_start(note_mask.pop_front(), note_cyc.pop_front());
        end

    initial
    begin
        #100000;
        fails++;
        results;
    end

    initial
    begin
        rstn = 1'b0;
        go = 1'b0;
        sel = 4'h0;
        pin_low_req = 2'h0;
        factor_wr = 4'h0;
        factor_wdata = 16'h0000;
        transfer_enable = 4'hF;
        level_mode = 1'b0;
        lfsr = 16'h149B;
        shadow = 16'h0000;
        tick(5);
        chk("factor after reset", 16'h0000, factor_rd);
        rstn = 1'b1;
        tick(3);
        repeat (8)
        begin
            lfsr = lfsr_next(lfsr);
            wr_all(lfsr);
            tick(1);
            chk("factor readback", shadow, factor_rd);
        end
        // a single-half write must leave the other three fields alone
        factor_wdata = ~shadow;
        factor_wr = 4'h2;
        tick(1);
        factor_wr = 4'h0;
        shadow[7:4] = factor_wdata[7:4];
        tick(1);
        chk("single half write", shadow, factor_rd);
        for (int h = 0; h < 4; h++)
            for (int c = 1; c < 14; c++)
                if (c == 1 || c > 3)
                begin
                    wr_all(16'(c) << (4 * h));
                    fire(4'(c), 4'(1 << h));
                    fire(c == 13 ? 4'h1 : 4'(c + 1), 4'h0);
                end
        wr_all(16'h1111);
        fire(4'h1, 4'hF);
        wr_all(16'h0880);
        fire(4'h8, 4'h6);
        foreach (bad[i])
        begin
            wr_all(bad[i]);
            pin_low_req = 2'h3;
            for (int c = 1; c < 14; c++)
                fire(4'(c), 4'h0);
            pin_low_req = 2'h0;
            tick(8);
        end
        wr_all(16'h3131);
        level_mode = 1'b1;
        pin_low_req = 2'h3;
        tick(20);
        // 0B outranks 1B, so 1B only gets its turn once the channel 0 pin is released
        pin_low_req = 2'h2;
        tick(20);
        pin_low_req = 2'h0;
        tick(12);
        level_mode = 1'b0;
        chk("low level starts 0B", 16'h0001, 16'(level_b >= 8));
        chk("low level starts 1B", 16'h0001, 16'(level_d >= 8));
        chk("pin starts on a half", 16'h0000, 16'(level_a));
        // enabling with the pin already low gives exactly one start on each of 0B and 1B
        wr_all(16'h2121);
        transfer_enable = 4'h5;
        pin_low_req = 2'h3;
        tick(10);
        note(4'hA);
        transfer_enable = 4'hF;
        tick(20);
        pin_low_req = 2'h0;
        tick(10);
        note(4'hA);
        pin_low_req = 2'h3;
        tick(20);
        pin_low_req = 2'h0;
        tick(10);
        chk("notes left over", 16'h0000, 16'(note_mask.size()));
        results;
    end
endmodule

// File: testbench/event_source_model.sv
// on-chip event sources and the two request pins seen by the selector
// assumes bench requests change shortly after the rising edge of sys_clk
module event_source_model
(
    // clock and bench requests
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic [3:0] sel,
    input  wire logic [1:0] pin_low_req,
    // events and pins towards the selector
    output logic            adc_conv_end,
    output logic      [1:0] serial_tx_end,
    output logic      [1:0] serial_rx_end,
    output logic      [5:0] timer_capture_a,
    output logic      [1:0] external_transfer_request_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] hit;
    initial
    begin
        {adc_conv_end, serial_tx_end, serial_rx_end, timer_capture_a} = 11'h000;
        external_transfer_request_n = 2'h3;
    end
    // event index equals the factor code, so a go lasting one cycle is one pulse
    always @(posedge sys_clk)
    begin
        hit = go ? 16'h0001 << sel : 16'h0000;
        adc_conv_end <= #1 hit[1];
        serial_tx_end <= #1 {hit[6], hit[4]};
        serial_rx_end <= #1 {hit[7], hit[5]};
        timer_capture_a <= #1 hit[13:8];
        // pins idle high behind their pull-ups when not pulled low
        external_transfer_request_n <= #1 ~pin_low_req;
    end
endmodule
